// >>> rtl/tcmp_top.sv
// Top of the 16-bit timer: counter, modes, flags and two output channels
// Operation
// - Count write blocks matches next timer cycle
// - Writing count equal compare gives no match
// - Output state survives waveform mode changes
// - New action select applies from next match
// - Action select drives update and pin source
// - Reset clears each output state flop
// - Nonzero select overrides general port value
// - Pin direction stays with port direction bit
// - Action select never touches input capture
// - Select zero leaves output state unchanged
// - Force strobe applies action immediately, non-PWM
// - Counting depends only on waveform mode
// - Select means none, toggle, clear, or set
// - Normal mode increments, wraps max to zero
// - Overflow flag set only when count wraps max to zero
// - Normal mode accepts count writes anytime
// - Clear-on-match clears at compare A/capture
// - Top flag set each time count reaches top
// - Unbuffered top below count wraps via max
// - Toggle at top gives half clock maximum
// - Overflow flag set on max to zero pass
// - Compare flag set one tick after match
// - Forced compare sets no flag, no clear
// - Compare registers unbuffered in these modes
`timescale 1ns/1ps
`include "tcmp_map.svh"
module tcmp_top (
	input wire logic I_CLK_SYS,
	input wire logic I_RSTN,
	input wire logic i_TICK,
	input wire tcmp_pkg::tcmp_wgm_t i_WAVEFORM_MODE_SELECT,
	input wire tcmp_pkg::tcmp_act_t i_OUTPUT_ACTION_SELECT_A,
	input wire tcmp_pkg::tcmp_act_t i_OUTPUT_ACTION_SELECT_B,
	input wire logic i_FORCE_COMPARE_STROBE_A,
	input wire logic i_FORCE_COMPARE_STROBE_B,
	input wire logic i_COUNT_WR,
	input wire tcmp_pkg::tcmp_count_t i_COUNT_WDATA,
	input wire logic i_CMP_A_WR,
	input wire logic i_CMP_B_WR,
	input wire logic i_CAP_WR,
	input wire tcmp_pkg::tcmp_count_t i_REG_WDATA,
	input wire logic i_CAPTURE_EVENT,
	input wire logic i_OVF_CLR,
	input wire logic i_OVF_ACK,
	input wire logic i_CMP_A_CLR,
	input wire logic i_CMP_A_ACK,
	input wire logic i_CMP_B_CLR,
	input wire logic i_CMP_B_ACK,
	input wire logic i_CAP_CLR,
	input wire logic i_CAP_ACK,
	input wire logic i_PORT_VAL_A,
	input wire logic i_PORT_DIR_A,
	input wire logic i_PORT_VAL_B,
	input wire logic i_PORT_DIR_B,
	output tcmp_pkg::tcmp_count_t o_TIMER_COUNT,
	output tcmp_pkg::tcmp_count_t o_COMPARE_VALUE_A,
	output tcmp_pkg::tcmp_count_t o_COMPARE_VALUE_B,
	output tcmp_pkg::tcmp_count_t o_CAPTURE_VALUE,
	output logic o_OVERFLOW_FLAG,
	output logic o_COMPARE_A_FLAG,
	output logic o_COMPARE_B_FLAG,
	output logic o_CAPTURE_FLAG,
	output logic o_COMPARE_OUTPUT_STATE_A,
	output logic o_COMPARE_OUTPUT_STATE_B,
	output logic o_PIN_A_VAL,
	output logic o_PIN_A_OE,
	output logic o_PIN_B_VAL,
	output logic o_PIN_B_OE
);
	import tcmp_pkg::*;

	// Count, compare and capture storage
	tcmp_count_t cnt_q;
	tcmp_count_t cnt_d;
	tcmp_count_t cmpa_q;
	tcmp_count_t cmpb_q;
	tcmp_count_t cap_q;

	// Flags and match pendings
	logic ovf_q;
	logic ocfa_q;
	logic ocfb_q;
	logic icf_q;
	logic pend_a_q;
	logic pend_b_q;
	logic pend_top_q;

	// Decoded conditions
	logic match_a;
	logic match_b;
	logic mode_ctc_a;
	logic mode_ctc_cap;
	logic non_pwm;
	logic at_top;
	logic wrap;
	logic mode_ctc;
	logic match_top;
	tcmp_count_t top_val;
	tcmp_count_t cnt_inc;
	logic ovf_set;
	logic icf_set;
	logic icf_clr;
	logic ocfa_set;
	logic ocfb_set;

	// Flag update: hardware set wins over any clear in the same cycle
	function automatic logic flag_next(input logic cur, input logic set, input logic clr);
		flag_next = set | (cur & ~clr);
	endfunction

	// Mode compare; the counting sequence hangs on this field alone
	function automatic logic mode_is(input tcmp_wgm_t m, input tcmp_wgm_t code);
		mode_is = (m == code);
	endfunction

	// Mode decode from the waveform mode field alone
	assign mode_ctc_a = mode_is(i_WAVEFORM_MODE_SELECT, `TCMP_WGM_CTC_A);
	assign mode_ctc_cap = mode_is(i_WAVEFORM_MODE_SELECT, `TCMP_WGM_CTC_CAP);
	assign mode_ctc = mode_ctc_a | mode_ctc_cap;
	// Only the three implemented modes allow a forced compare
	assign non_pwm = mode_is(i_WAVEFORM_MODE_SELECT, `TCMP_WGM_NORMAL) | mode_ctc;

	// Top value follows the mode: compare A in mode 4, capture value in mode C
	assign top_val = mode_ctc_cap ? cap_q : cmpa_q;

	// Top reached in a clear-on-match mode; a count write blocks it like a match.
	// A top below the live count is simply missed, so the count runs on to max.
	assign at_top = mode_ctc & match_top;
	assign wrap = i_TICK & (cnt_q == `TCMP_COUNT_MAX);

	// Plain increment, wrapping from max to zero by its own width
	assign cnt_inc = cnt_q + 16'h0001;

	// Next count: clear on top in clear-on-match modes, else plain increment
	always_comb begin
		cnt_d = cnt_q;
		if (i_TICK) begin
			if (at_top) begin
				cnt_d = `TCMP_COUNT_BOTTOM;
			end else begin
				cnt_d = cnt_inc;
			end
		end
	end

	// Counter register; a software write always takes priority.
	// A tick lost to a write is covered by the blocking window that follows,
	// so the written value is never compared in the cycle it lands.
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			cnt_q <= `TCMP_COUNT_BOTTOM;
		end else if (i_COUNT_WR) begin
			cnt_q <= i_COUNT_WDATA;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Compare register A written directly, no buffering
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			cmpa_q <= 16'h0000;
		end else if (i_CMP_A_WR) begin
			cmpa_q <= i_REG_WDATA;
		end
	end

	// Compare register B written directly, no buffering
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			cmpb_q <= 16'h0000;
		end else if (i_CMP_B_WR) begin
			cmpb_q <= i_REG_WDATA;
		end
	end

	// Capture register: software load or capture of the live count.
	// In mode C it holds top, so capture events must not disturb it.
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			cap_q <= 16'h0000;
		end else if (i_CAP_WR) begin
			cap_q <= i_REG_WDATA;
		end else if (i_CAPTURE_EVENT & ~mode_ctc_cap) begin
			cap_q <= cnt_q;
		end
	end

	// Comparators with match blocking after count writes
	tcmp_match u_match_a (
		.i_clk(I_CLK_SYS),
		.i_rstn(I_RSTN),
		.i_tick(i_TICK),
		.i_cnt_wr(i_COUNT_WR),
		.i_count(cnt_q),
		.i_cmp(cmpa_q),
		.o_match(match_a)
	);
	tcmp_match u_match_b (
		.i_clk(I_CLK_SYS),
		.i_rstn(I_RSTN),
		.i_tick(i_TICK),
		.i_cnt_wr(i_COUNT_WR),
		.i_count(cnt_q),
		.i_cmp(cmpb_q),
		.o_match(match_b)
	);

	// Top comparator: a count write blocks the clear exactly as it blocks a match
	tcmp_match u_match_top (
		.i_clk(I_CLK_SYS),
		.i_rstn(I_RSTN),
		.i_tick(i_TICK),
		.i_cnt_wr(i_COUNT_WR),
		.i_count(cnt_q),
		.i_cmp(top_val),
		.o_match(match_top)
	);

	// Match A pending: the flag follows one tick after the match.
	// A tick with no new match drops it; a match on that tick re-arms it.
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			pend_a_q <= 1'b0;
		end else if (match_a) begin
			pend_a_q <= 1'b1;
		end else if (i_TICK) begin
			pend_a_q <= 1'b0;
		end
	end

	// Match B pending, same timing as channel A
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			pend_b_q <= 1'b0;
		end else if (match_b) begin
			pend_b_q <= 1'b1;
		end else if (i_TICK) begin
			pend_b_q <= 1'b0;
		end
	end

	// Top pending in capture-top mode; feeds the capture flag a tick later
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			pend_top_q <= 1'b0;
		end else if (at_top & mode_ctc_cap) begin
			pend_top_q <= 1'b1;
		end else if (i_TICK) begin
			pend_top_q <= 1'b0;
		end
	end

	// Flag set terms: a pending match lands on the next tick; force has no path here
	assign ocfa_set = pend_a_q & i_TICK;
	assign ocfb_set = pend_b_q & i_TICK;
	assign icf_set = (pend_top_q & i_TICK) | (i_CAPTURE_EVENT & ~mode_ctc_cap);
	assign icf_clr = i_CAP_CLR | i_CAP_ACK;
	assign ovf_set = wrap & ~i_COUNT_WR;

	// Compare flag A, set only by real matches
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ocfa_q <= 1'b0;
		end else begin
			ocfa_q <= flag_next(ocfa_q, ocfa_set, i_CMP_A_CLR | i_CMP_A_ACK);
		end
	end

	// Compare flag B, set only by real matches
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ocfb_q <= 1'b0;
		end else begin
			ocfb_q <= flag_next(ocfb_q, ocfb_set, i_CMP_B_CLR | i_CMP_B_ACK);
		end
	end

	// Capture flag: top in capture-top mode, or capture event otherwise
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			icf_q <= 1'b0;
		end else begin
			icf_q <= flag_next(icf_q, icf_set, icf_clr);
		end
	end

	// Overflow flag set as the count passes max to zero
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ovf_q <= 1'b0;
		end else begin
			ovf_q <= flag_next(ovf_q, ovf_set, i_OVF_CLR | i_OVF_ACK);
		end
	end

	// Output channels; select bits only steer outputs
	tcmp_out_unit u_out_a (
		.i_clk(I_CLK_SYS),
		.i_rstn(I_RSTN),
		.i_act(i_OUTPUT_ACTION_SELECT_A),
		.i_match(match_a),
		.i_force(i_FORCE_COMPARE_STROBE_A),
		.i_non_pwm(non_pwm),
		.i_port_val(i_PORT_VAL_A),
		.i_port_dir(i_PORT_DIR_A),
		.o_state(o_COMPARE_OUTPUT_STATE_A),
		.o_pin_val(o_PIN_A_VAL),
		.o_pin_oe(o_PIN_A_OE)
	);

	// Channel B mirrors channel A with its own select, force and port bits
	tcmp_out_unit u_out_b (
		.i_clk(I_CLK_SYS),
		.i_rstn(I_RSTN),
		.i_act(i_OUTPUT_ACTION_SELECT_B),
		.i_match(match_b),
		.i_force(i_FORCE_COMPARE_STROBE_B),
		.i_non_pwm(non_pwm),
		.i_port_val(i_PORT_VAL_B),
		.i_port_dir(i_PORT_DIR_B),
		.o_state(o_COMPARE_OUTPUT_STATE_B),
		.o_pin_val(o_PIN_B_VAL),
		.o_pin_oe(o_PIN_B_OE)
	);

	// Register views
	assign o_TIMER_COUNT = cnt_q;
	assign o_COMPARE_VALUE_A = cmpa_q;
	assign o_COMPARE_VALUE_B = cmpb_q;
	assign o_CAPTURE_VALUE = cap_q;

	// Flag views
	assign o_OVERFLOW_FLAG = ovf_q;
	assign o_COMPARE_A_FLAG = ocfa_q;
	assign o_COMPARE_B_FLAG = ocfb_q;
	assign o_CAPTURE_FLAG = icf_q;
endmodule

// >>> rtl/tcmp_map.svh
// Constants for the 16-bit timer compare and waveform output block
`ifndef TCMP_MAP_SVH
`define TCMP_MAP_SVH
`define TCMP_WGM_NORMAL 4'h0
`define TCMP_WGM_CTC_A 4'h4
`define TCMP_WGM_CTC_CAP 4'hC
`define TCMP_COUNT_MAX 16'hFFFF
`define TCMP_COUNT_BOTTOM 16'h0000
`define TCMP_OCS_RESET 1'h0
`define TCMP_ACT_NONE 2'h0
`define TCMP_ACT_TOGGLE 2'h1
`define TCMP_ACT_CLEAR 2'h2
`define TCMP_ACT_SET 2'h3
`endif

// >>> rtl/tcmp_pkg.sv
// Types for the 16-bit timer compare and waveform output block
package tcmp_pkg;
	typedef logic [15:0] tcmp_count_t;
	typedef logic [1:0] tcmp_act_t;
	typedef logic [3:0] tcmp_wgm_t;
endpackage

// >>> rtl/tcmp_out_unit.sv
// One compare output channel: output state flop and pin override
`timescale 1ns/1ps
`include "tcmp_map.svh"
module tcmp_out_unit (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire tcmp_pkg::tcmp_act_t i_act,
	input wire logic i_match,
	input wire logic i_force,
	input wire logic i_non_pwm,
	input wire logic i_port_val,
	input wire logic i_port_dir,
	output logic o_state,
	output logic o_pin_val,
	output logic o_pin_oe
);
	import tcmp_pkg::*;
	logic state_q;
	logic apply;

	// Apply the action on a real match or on a force in non-PWM modes
	assign apply = i_match | (i_force & i_non_pwm);

	// Output state flop; mode changes never touch it
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= `TCMP_OCS_RESET;
		end else if (apply) begin
			unique case (i_act)
				`TCMP_ACT_NONE: state_q <= state_q;
				`TCMP_ACT_TOGGLE: state_q <= ~state_q;
				`TCMP_ACT_CLEAR: state_q <= 1'b0;
				`TCMP_ACT_SET: state_q <= 1'b1;
			endcase
		end
	end

	assign o_state = state_q;
	// Override port data when any select bit is set; direction stays with port
	assign o_pin_val = (|i_act) ? state_q : i_port_val;
	assign o_pin_oe = i_port_dir;
endmodule

// >>> rtl/tcmp_match.sv
// Compare with blocking window after a software count write
`timescale 1ns/1ps
module tcmp_match (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_tick,
	input wire logic i_cnt_wr,
	input wire tcmp_pkg::tcmp_count_t i_count,
	input wire tcmp_pkg::tcmp_count_t i_cmp,
	output logic o_match
);
	import tcmp_pkg::*;
	logic block_q;

	// Block stays armed from a count write until the next timer tick consumes it
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			block_q <= 1'b0;
		end else if (i_cnt_wr) begin
			block_q <= 1'b1;
		end else if (i_tick) begin
			block_q <= 1'b0;
		end
	end

	// Match qualified by tick, suppressed in the blocked cycle
	assign o_match = i_tick & (i_count == i_cmp) & ~block_q & ~i_cnt_wr;
endmodule

// >>> test/tcmp_top_properties.sv
// Port-level assertions for the timer compare block
`timescale 1ns/1ps
`include "tcmp_map.svh"
module tcmp_top_properties (
	input wire logic I_CLK_SYS,
	input wire logic I_RSTN,
	input wire logic i_TICK,
	input wire tcmp_pkg::tcmp_wgm_t i_WAVEFORM_MODE_SELECT,
	input wire tcmp_pkg::tcmp_act_t i_OUTPUT_ACTION_SELECT_A,
	input wire logic i_FORCE_COMPARE_STROBE_A,
	input wire logic i_COUNT_WR,
	input wire logic i_PORT_VAL_A,
	input wire logic i_PORT_DIR_A,
	input wire tcmp_pkg::tcmp_count_t o_TIMER_COUNT,
	input wire tcmp_pkg::tcmp_count_t o_COMPARE_VALUE_A,
	input wire tcmp_pkg::tcmp_count_t o_CAPTURE_VALUE,
	input wire logic o_OVERFLOW_FLAG,
	input wire logic o_COMPARE_A_FLAG,
	input wire logic o_COMPARE_OUTPUT_STATE_A,
	input wire logic o_PIN_A_VAL,
	input wire logic o_PIN_A_OE
);
	import tcmp_pkg::*;
	logic blk_q, pnd_q, ok, np, clear_on_match_mode, hit, st, fo;
	tcmp_wgm_t md;
	tcmp_act_t sl;
	tcmp_count_t cn, top;
	// Short names; a match counts only on a tick outside the write block
	assign md = i_WAVEFORM_MODE_SELECT;
	assign sl = i_OUTPUT_ACTION_SELECT_A;
	assign cn = o_TIMER_COUNT;
	assign st = o_COMPARE_OUTPUT_STATE_A;
	assign fo = i_FORCE_COMPARE_STROBE_A;
	assign clear_on_match_mode = (md == `TCMP_WGM_CTC_A) | (md == `TCMP_WGM_CTC_CAP);
	assign np = clear_on_match_mode | (md == `TCMP_WGM_NORMAL);
	assign top = (md == `TCMP_WGM_CTC_A) ? o_COMPARE_VALUE_A : o_CAPTURE_VALUE;
	assign ok = i_TICK & ~i_COUNT_WR & ~blk_q;
	assign hit = ok & np & (cn == o_COMPARE_VALUE_A);
	// Block stays armed until a tick uses it; flag is owed one tick after a match
	always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
		if (!I_RSTN) begin
			blk_q <= 1'h0;
			pnd_q <= 1'h0;
		end else begin
			blk_q <= i_COUNT_WR | (blk_q & ~i_TICK);
			pnd_q <= hit | (pnd_q & ~i_TICK);
		end
	end
	default clocking dck @(posedge I_CLK_SYS);
	endclocking
	default disable iff (!I_RSTN);
	AST_PIN_SRC: assert property (o_PIN_A_VAL == ((sl != 2'h0) ? st : i_PORT_VAL_A))
		else $error("pin source wrong");
	AST_PIN_DIR: assert property (o_PIN_A_OE == i_PORT_DIR_A)
		else $error("pin enable wrong");
	AST_RST_STATE: assert property ($rose(I_RSTN) |-> st == `TCMP_OCS_RESET)
		else $error("state not cleared by reset");
	AST_NORM_INC: assert property (i_TICK && !i_COUNT_WR && md == `TCMP_WGM_NORMAL
		|=> cn == $past(cn) + 16'h0001) else $error("count did not step");
	AST_OVF_SET: assert property (i_TICK && !i_COUNT_WR && np && cn == `TCMP_COUNT_MAX
		|=> o_OVERFLOW_FLAG) else $error("overflow flag missing");
	AST_CTC_TOP: assert property (ok && clear_on_match_mode && cn == top |=> cn == `TCMP_COUNT_BOTTOM)
		else $error("count not cleared at top");
	AST_FLAG_SET: assert property (pnd_q && i_TICK |=> o_COMPARE_A_FLAG)
		else $error("compare flag missing");
	AST_FLAG_CAUSE: assert property ($rose(o_COMPARE_A_FLAG) |-> $past(pnd_q && i_TICK))
		else $error("compare flag without match");
	AST_TOGGLE: assert property (hit && sl == `TCMP_ACT_TOGGLE && !fo |=> st != $past(st))
		else $error("no toggle on match");
	AST_HOLD: assert property (sl == `TCMP_ACT_NONE |=> $stable(st))
		else $error("state moved with no action");
	AST_BLOCK: assert property ((i_COUNT_WR || blk_q) && !fo |=> $stable(st))
		else $error("match not blocked after write");
	AST_FORCE: assert property (fo && np && sl == `TCMP_ACT_SET |=> st)
		else $error("force set failed");
	CV_TOP: cover property (ok && clear_on_match_mode && cn == top);
	CV_FORCE: cover property (fo && np);
	CV_OVF: cover property ($rose(o_OVERFLOW_FLAG));
endmodule
bind tcmp_top tcmp_top_properties u_props (.*);

// >>> test/tb_top.sv
// Self-checking bench for the timer compare block
`timescale 1ns/1ps
`include "tcmp_map.svh"
`define CHK(n,e,g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
	import tcmp_pkg::*;
	localparam logic [5:0] CLR = 6'h20, ACK = 6'h10, FRC = 6'h08, CW = 6'h04, AW = 6'h02, PW = 6'h01;
	logic clk = 1'h0, rstn = 1'h0, tick = 1'h0, pv = 1'h0, pd = 1'h0;
	logic [5:0] c = 6'h00;
	tcmp_wgm_t mode = 4'h0;
	tcmp_act_t sel = 2'h0;
	tcmp_count_t wd = 16'h0000, top, cnt, cmpa;
	logic ovf, fa, fc, st, pinv, pine, s0;
	logic cev = 1'h0, stb, fb, pinbv, pinbe;
	tcmp_count_t cmpb, capv;
	int n_mismatch = 0, n_tests = 0, nt;
	logic [31:0] rnd = 32'h00011585; // Fixed seed
	tcmp_top dut (.I_CLK_SYS(clk), .I_RSTN(rstn), .i_TICK(tick), .i_WAVEFORM_MODE_SELECT(mode),
		.i_OUTPUT_ACTION_SELECT_A(sel), .i_OUTPUT_ACTION_SELECT_B(sel),
		.i_FORCE_COMPARE_STROBE_A(c[3]), .i_FORCE_COMPARE_STROBE_B(c[3]),
		.i_COUNT_WR(c[2]), .i_COUNT_WDATA(wd), .i_CMP_A_WR(c[1]), .i_CMP_B_WR(c[1]),
		.i_CAP_WR(c[0]), .i_REG_WDATA(wd), .i_CAPTURE_EVENT(cev), .i_OVF_CLR(c[5]),
		.i_OVF_ACK(c[4]), .i_CMP_A_CLR(c[5]), .i_CMP_A_ACK(c[4]), .i_CMP_B_CLR(c[5]),
		.i_CMP_B_ACK(c[4]), .i_CAP_CLR(c[5]), .i_CAP_ACK(c[4]), .i_PORT_VAL_A(pv),
		.i_PORT_DIR_A(pd), .i_PORT_VAL_B(pv), .i_PORT_DIR_B(pd), .o_TIMER_COUNT(cnt),
		.o_COMPARE_VALUE_A(cmpa), .o_COMPARE_VALUE_B(cmpb), .o_CAPTURE_VALUE(capv),
		.o_OVERFLOW_FLAG(ovf), .o_COMPARE_A_FLAG(fa), .o_COMPARE_B_FLAG(fb),
		.o_CAPTURE_FLAG(fc), .o_COMPARE_OUTPUT_STATE_A(st), .o_COMPARE_OUTPUT_STATE_B(stb),
		.o_PIN_A_VAL(pinv), .o_PIN_A_OE(pine), .o_PIN_B_VAL(pinbv), .o_PIN_B_OE(pinbe));
	// Random source and expected output state after an action
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic act(input tcmp_act_t s, input logic p);
		return (s == `TCMP_ACT_NONE) ? p : (s == `TCMP_ACT_TOGGLE) ? ~p : s[0];
	endfunction
	// One-cycle strobes, tick pulses and configuration
	task automatic pl(input logic [5:0] k, input tcmp_count_t v);
		@(posedge clk);
		c <= k;
		wd <= v;
		@(posedge clk);
		c <= 6'h00;
		#1;
	endtask
	task automatic tk();
		@(posedge clk);
		tick <= 1'h1;
		@(posedge clk);
		tick <= 1'h0;
		#1;
	endtask
	task automatic cfg(input tcmp_wgm_t m, input tcmp_act_t s, input logic t);
		@(posedge clk);
		mode <= m;
		sel <= s;
		tick <= t;
		#1;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic results();
		$display("TB: checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Clock and watchdog
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		results();
	end
	// Main sequence
	initial begin
		step(3);
		rstn <= 1'h1;
		`CHK("state", 1'h0, st)
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			@(posedge clk);
			sel <= rnd[1:0];
			pv <= rnd[2];
			pd <= rnd[3];
			#1;
			`CHK("pin", (rnd[1:0] != 2'h0) ? st : rnd[2], pinv)
			`CHK("oe", rnd[3], pine)
			`CHK("pinb", (rnd[1:0] != 2'h0) ? 1'h0 : rnd[2], pinbv)
			`CHK("oeb", rnd[3], pinbe)
		end
		for (int s = 0; s < 4; s++) begin
			cfg(`TCMP_WGM_NORMAL, s[1:0], 1'h0);
			s0 = st;
			pl(FRC, 16'h0000);
			`CHK("force", act(s[1:0], s0), st)
			`CHK("fflag", 1'h0, fa)
			`CHK("forceb", act(s[1:0], s0), stb)
			`CHK("fflagb", 1'h0, fb)
			`CHK("fcnt", 16'h0000, cnt)
		end
		cfg(`TCMP_WGM_CTC_CAP, `TCMP_ACT_NONE, 1'h0);
		cfg(`TCMP_WGM_CTC_A, `TCMP_ACT_NONE, 1'h0);
		`CHK("keep", 1'h1, st)
		rnd = lfsr(rnd);
		top = {1'h0, rnd[14:0]};
		cfg(`TCMP_WGM_NORMAL, `TCMP_ACT_TOGGLE, 1'h0);
		pl(AW, top);
		`CHK("cmpa", top, cmpa)
		`CHK("cmpb", top, cmpb)
		pl(CW, top);
		s0 = st;
		tk();
		`CHK("blk", s0, st)
		`CHK("cnt", top + 16'h0001, cnt)
		tk();
		`CHK("noflag", 1'h0, fa)
		pl(AW, top + 16'h0002);
		cfg(`TCMP_WGM_NORMAL, `TCMP_ACT_CLEAR, 1'h0);
		tk();
		`CHK("match", 1'h0, st)
		`CHK("late", 1'h0, fa)
		tk();
		`CHK("flag", 1'h1, fa)
		`CHK("flagb", 1'h1, fb)
		pl(CLR, 16'h0000);
		`CHK("clr", 1'h0, fa)
		pl(CW, 16'h1234);
		@(posedge clk);
		cev <= 1'h1;
		@(posedge clk);
		cev <= 1'h0;
		#1;
		`CHK("cap", 16'h1234, capv)
		`CHK("capflag", 1'h1, fc)
		cfg(`TCMP_WGM_NORMAL, `TCMP_ACT_NONE, 1'h1);
		pl(CW, 16'hFFFE);
		step(1);
		`CHK("max", `TCMP_COUNT_MAX, cnt)
		`CHK("noovf", 1'h0, ovf)
		step(1);
		`CHK("wrap", `TCMP_COUNT_BOTTOM, cnt)
		`CHK("ovf", 1'h1, ovf)
		pl(ACK, 16'h0000);
		`CHK("ack", 1'h0, ovf)
		cfg(`TCMP_WGM_CTC_A, `TCMP_ACT_NONE, 1'h1);
		pl(AW, 16'h0005);
		pl(CW, 16'hFFF0);
		step(16);
		`CHK("ctcwrap", 16'h0000, cnt)
		`CHK("ctcovf", 1'h1, ovf)
		step(5);
		`CHK("top", 16'h0005, cnt)
		step(1);
		`CHK("clear", 16'h0000, cnt)
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			top = (i < 3) ? 16'(i) : {13'h0000, rnd[2:0]};
			cfg(i[0] ? `TCMP_WGM_CTC_CAP : `TCMP_WGM_CTC_A, `TCMP_ACT_TOGGLE, 1'h1);
			pl(AW | PW, top);
			`CHK("topval", top, i[0] ? capv : cmpa)
			pl(CW | CLR, top - 16'h0001);
			step(2 * top + 4);
			nt = 0;
			repeat (4 * top + 4) begin
				s0 = st;
				step(1);
				nt += (st !== s0);
			end
			`CHK("toggles", 4, nt)
			`CHK("topflag", 1'h1, i[0] ? fc : fa)
			`CHK("flagbtop", 1'h1, fb)
		end
		results();
	end
endmodule
